// ---- rtl/thp_core.v ----
`timescale 1ns/10ps
`include "thp_regs.vh"
// Overview of operation
// - Low supply comparator reporting below threshold raises the interrupt request.
// - Wake-up period programmable from 1 ms to 255 * 2^31 ms (over 17 years).
// - Timer calibrates at start-up and every 30 s for 500 us.
// - Duty cycle mode: each timer expiry opens a short receive window.
// - External interrupt input is active low; falling pulse is an event.
// - Interrupt output low on tx ready, fifo, error, ext, wake, supply, reset.
// - One shared flag: rx overflow when receiving, tx underrun when transmitting.
// - Host reads status word; that read clears the events it reported.
// - Two byte stages form one 16-bit shifter, shifted at the bit rate.
// - Transmit latch preloaded with alternating pattern as preamble.
// - Transmit register disabled: carrier follows the select pin level.
// - 16-bit receive fifo flags when programmed 1 to 16 bit level reached.
// - Fifo fills only after the sync pattern; sync bits never stored.
// - Fifo select: first fifo bit appears on the next serial clock.
// - Chip select high resets the serial interface, dropping partial words.
// - Mode 0 link; input sampled on rising serial clock while selected.
// - Status output changes on falling serial clock, fifo bits on rising; most significant bit first.
// - Serial output driven low while chip select is high.
module thp_core #(
  parameter [31:0] MS_CYCLES     = `THP_MS_CYCLES,
  parameter [31:0] CAL_CYCLES    = `THP_CAL_CYCLES,
  parameter [31:0] CAL_PERIOD_MS = `THP_CAL_PERIOD_MS,
  parameter        DEPTH         = `THP_FIFO_DEPTH
) (
  // Clock and control
  input  wire        clk,
  input  wire        sys_rst,
  input  wire        ce,
  // Serial command port
  input  wire        spi_sck,
  input  wire        spi_cs_n,
  input  wire        spi_sdi,
  output wire        spi_sdo,
  // Other pins
  input  wire        txdata_fifo_select_pin,
  input  wire        ext_int_n,
  input  wire        low_supply_det,
  output wire        irq_request_out_n,
  output wire        fifo_full_pin,
  output wire        tx_mod_out,
  // Configuration
  input  wire        tx_reg_en,
  input  wire        tx_active,
  input  wire        fifo_en,
  input  wire        rx_active,
  input  wire [4:0]  fifo_level,
  input  wire [4:0]  sync_len,
  input  wire [15:0] sync_pattern_setting,
  input  wire        duty_cycle_en,
  input  wire [6:0]  duty_cycle_setting,
  input  wire        wut_en,
  input  wire [7:0]  wut_mant,
  input  wire [4:0]  wut_exp,
  input  wire        osc_on,
  // Baseband bit streams
  input  wire        tx_bit_stb,
  input  wire        rx_bit_stb,
  input  wire        rx_bit,
  // Status
  output wire [15:0] status_word,
  output wire        tx_underrun_rx_overflow_flag,
  output wire        fifo_level_flag,
  output wire        rx_enable,
  output wire        osc_req,
  output wire        cal_busy
);

  localparam RX_HUNT = 1'b0;
  localparam RX_FILL = 1'b1;

  // Synchronised pins and edge history
  wire [5:0]  pin_s;
  wire        sck_s;
  wire        cs_n_s;
  wire        sdi_s;
  wire        fsel_s;
  wire        ext_s;
  wire        low_s;
  reg         sck_d_q;
  reg         cs_n_d_q;
  reg         ext_d_q;
  reg         low_d_q;
  // Serial engine
  reg  [15:0] in_sr_q;
  reg  [3:0]  bit_cnt_q;
  reg  [15:0] out_sr_q;
  reg  [15:0] snap_q;
  reg         fifo_bit_q;
  // Transmit path
  reg  [15:0] tx_shift_q;
  reg  [2:0]  tx_cnt_q;
  reg  [7:0]  tx_pend_q;
  reg         tx_pend_v_q;
  reg         tx_mod_q;
  // Receive path
  reg  [15:0] hunt_q;
  reg         rx_state_q;
  wire [DEPTH-1:0] mem_q;
  reg  [3:0]  wr_ptr_q;
  reg  [3:0]  rd_ptr_q;
  reg  [4:0]  fcnt_q;
  reg         lvl_q;
  // Duty cycle window
  reg         dc_win_q;
  reg  [6:0]  dc_cnt_q;
  reg         rx_en_q;
  // Sticky event flags and interrupt
  reg         txrdy_q;
  reg         por_q;
  reg         uo_q;
  reg         wake_q;
  reg         ext_q;
  reg         low_q;
  reg         irq_n_q;
  // Wake-up timer
  wire        ms_tick;
  wire        wut_expire;

  thp_sync #(
    .W       (6),
    .RST_VAL (`THP_PIN_RST)
  ) u_pins (
    .clk     (clk),
    .sys_rst (sys_rst),
    .ce      (ce),
    .d       ({low_supply_det, ext_int_n, txdata_fifo_select_pin,
               spi_sdi, spi_cs_n, spi_sck}),
    .q       (pin_s)
  );

  thp_wut #(
    .MS_CYCLES     (MS_CYCLES),
    .CAL_CYCLES    (CAL_CYCLES),
    .CAL_PERIOD_MS (CAL_PERIOD_MS)
  ) u_wut (
    .clk        (clk),
    .sys_rst    (sys_rst),
    .ce         (ce),
    .wut_en     (wut_en),
    .osc_on     (osc_on),
    .wut_mant   (wut_mant),
    .wut_exp    (wut_exp),
    .ms_tick    (ms_tick),
    .wut_expire (wut_expire),
    .cal_busy   (cal_busy),
    .osc_req    (osc_req)
  );

  assign sck_s  = pin_s[0];
  assign cs_n_s = pin_s[1];
  assign sdi_s  = pin_s[2];
  assign fsel_s = pin_s[3];
  assign ext_s  = pin_s[4];
  assign low_s  = pin_s[5];

  wire sck_rise = sck_s & ~sck_d_q;
  wire sck_fall = ~sck_s & sck_d_q;
  wire cs_fall  = ~cs_n_s & cs_n_d_q;
  wire selected = ~cs_n_s;
  // Fifo readout only in receive mode; in transmit mode sdo keeps the status shifter
  wire fifo_rd_mode = selected & fsel_s & fifo_en & ~tx_reg_en;

  // Command word assembly
  wire        cmd_bit   = selected & sck_rise & ~fifo_rd_mode;
  wire        word_done = cmd_bit & (bit_cnt_q == 4'hF);
  wire [15:0] word      = {in_sr_q[14:0], sdi_s};
  wire        status_rd = word_done & ~word[`THP_CMD_TYPE_BIT];
  wire        tx_wr     = word_done & (word[15:8] == `THP_OP_TXBYTE);
  wire [15:0] clr_mask  = status_rd ? snap_q : `THP_ST_RESET;

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sck_d_q    <= 1'b0;
      cs_n_d_q   <= 1'b1;
      ext_d_q    <= 1'b1;
      low_d_q    <= 1'b0;
      in_sr_q    <= 16'h0000;
      bit_cnt_q  <= 4'h0;
      out_sr_q   <= 16'h0000;
      snap_q     <= 16'h0000;
    end else if (ce) begin
      sck_d_q  <= sck_s;
      cs_n_d_q <= cs_n_s;
      ext_d_q  <= ext_s;
      low_d_q  <= low_s;
      if (cs_n_s) begin
        in_sr_q   <= 16'h0000;
        bit_cnt_q <= 4'h0;
      end else if (cmd_bit) begin
        in_sr_q   <= word;
        bit_cnt_q <= bit_cnt_q + 4'h1;
      end
      // Snapshot taken at select so only reported events get cleared
      if (cs_fall) begin
        out_sr_q <= status_word;
        snap_q   <= status_word;
      end else if (selected & sck_fall) begin
        out_sr_q <= {out_sr_q[14:0], 1'b0};
      end
    end
  end

  // Mux of flops: saves a cycle of turnaround on the falling edge
  assign spi_sdo = cs_n_s ? 1'b0 : (fifo_rd_mode ? fifo_bit_q : out_sr_q[15]);

  // Transmit shifter
  wire       tx_step     = tx_reg_en & tx_active & tx_bit_stb;
  wire       tx_boundary = tx_step & (tx_cnt_q == 3'h7);
  wire       tx_ready_ev = tx_boundary;
  wire       tx_underrun = tx_boundary & ~tx_pend_v_q & ~tx_wr;
  wire [7:0] tx_fill     = tx_wr ? word[7:0] : tx_pend_q;

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tx_shift_q  <= `THP_TX_PRELOAD;
      tx_cnt_q    <= 3'h0;
      tx_pend_q   <= 8'h00;
      tx_pend_v_q <= 1'b0;
      tx_mod_q    <= 1'b0;
    end else if (ce) begin
      if (!tx_reg_en) begin
        tx_shift_q  <= `THP_TX_PRELOAD;
        tx_cnt_q    <= 3'h0;
        tx_pend_v_q <= 1'b0;
        tx_mod_q    <= fsel_s;
      end else begin
        if (tx_step) begin
          tx_cnt_q <= tx_cnt_q + 3'h1;
          if (tx_boundary) begin
            tx_shift_q <= {tx_shift_q[14:7], tx_fill};
          end else begin
            tx_shift_q <= {tx_shift_q[14:0], 1'b0};
          end
        end
        if (tx_wr) begin
          tx_pend_q   <= word[7:0];
          tx_pend_v_q <= ~tx_boundary;
        end else if (tx_boundary) begin
          tx_pend_v_q <= 1'b0;
        end
        tx_mod_q <= tx_active & tx_shift_q[15];
      end
    end
  end

  assign tx_mod_out = tx_mod_q;

  // Receive: sync hunt then fifo fill
  wire        rx_go     = rx_en_q & rx_bit_stb;
  wire [15:0] hunt_next = {hunt_q[14:0], rx_bit};
  wire [15:0] sync_mask = ~(16'hFFFF << sync_len);
  wire        sync_hit  = ((hunt_next ^ sync_pattern_setting) & sync_mask) == 16'h0000;
  wire        push      = (rx_state_q == RX_FILL) & rx_go & fifo_en & ~tx_reg_en;
  wire        pop       = fifo_rd_mode & sck_rise & (fcnt_q != 5'h00);
  wire        rx_ovf    = push & (fcnt_q == DEPTH[4:0]) & ~pop;
  wire        push_ok   = push & ~rx_ovf;

  genvar gi;
  generate
    for (gi = 0; gi < DEPTH; gi = gi + 1) begin : g_mem
      localparam [3:0] IDX = gi;
      reg cell_q;
      always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
          cell_q <= 1'b0;
        end else if (ce && push_ok && wr_ptr_q == IDX) begin
          cell_q <= rx_bit;
        end
      end
      assign mem_q[gi] = cell_q;
    end
  endgenerate

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      hunt_q     <= 16'h0000;
      rx_state_q <= RX_HUNT;
      wr_ptr_q   <= 4'h0;
      rd_ptr_q   <= 4'h0;
      fcnt_q     <= 5'h00;
      fifo_bit_q <= 1'b0;
      lvl_q      <= 1'b0;
    end else if (ce) begin
      case (rx_state_q)
        RX_HUNT: begin
          if (rx_go) begin
            hunt_q <= hunt_next;
          end
          // Sync bits stay in the hunter, never enter the fifo
          if (rx_go && fifo_en && !tx_reg_en && sync_hit) begin
            rx_state_q <= RX_FILL;
          end
        end
        RX_FILL: begin
          if (!fifo_en || tx_reg_en) begin
            rx_state_q <= RX_HUNT;
            hunt_q     <= 16'h0000;
          end
        end
        default: rx_state_q <= RX_HUNT;
      endcase
      if (!fifo_en) begin
        wr_ptr_q <= 4'h0;
        rd_ptr_q <= 4'h0;
        fcnt_q   <= 5'h00;
      end else begin
        if (push_ok) begin
          wr_ptr_q <= wr_ptr_q + 4'h1;
        end
        if (pop) begin
          rd_ptr_q   <= rd_ptr_q + 4'h1;
          fifo_bit_q <= mem_q[rd_ptr_q];
        end
        if (push_ok && !pop) begin
          fcnt_q <= fcnt_q + 5'h01;
        end else if (pop && !push_ok) begin
          fcnt_q <= fcnt_q - 5'h01;
        end
      end
      lvl_q <= fifo_en & (fcnt_q != 5'h00) & (fcnt_q >= fifo_level);
    end
  end

  assign fifo_full_pin   = fifo_en & lvl_q;
  assign fifo_level_flag = lvl_q;

  // Duty cycle receive window, counted in milliseconds
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      dc_win_q <= 1'b0;
      dc_cnt_q <= 7'h00;
      rx_en_q  <= 1'b0;
    end else if (ce) begin
      if (!duty_cycle_en) begin
        dc_win_q <= 1'b0;
      end else if (wut_expire) begin
        dc_win_q <= 1'b1;
        dc_cnt_q <= duty_cycle_setting;
      end else if (dc_win_q && ms_tick) begin
        if (dc_cnt_q == 7'h00) begin
          dc_win_q <= 1'b0;
        end else begin
          dc_cnt_q <= dc_cnt_q - 7'h01;
        end
      end
      rx_en_q <= rx_active | dc_win_q;
    end
  end

  assign rx_enable = rx_en_q;

  // Sticky events: a set in the clearing cycle survives
  wire ext_ev = ext_d_q & ~ext_s;
  wire low_ev = low_s & ~low_d_q;
  wire uo_ev  = tx_underrun | rx_ovf;

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      txrdy_q <= 1'b0;
      por_q   <= 1'b1;
      uo_q    <= 1'b0;
      wake_q  <= 1'b0;
      ext_q   <= 1'b0;
      low_q   <= 1'b0;
      irq_n_q <= 1'b0;
    end else if (ce) begin
      txrdy_q <= (txrdy_q & ~clr_mask[`THP_ST_TXRDY_FIFO]) | tx_ready_ev;
      por_q   <= por_q & ~clr_mask[`THP_ST_POR];
      uo_q    <= (uo_q & ~clr_mask[`THP_ST_UNDOVF]) | uo_ev;
      wake_q  <= (wake_q & ~clr_mask[`THP_ST_WAKE]) | wut_expire;
      ext_q   <= (ext_q & ~clr_mask[`THP_ST_EXTINT]) | ext_ev;
      low_q   <= (low_q & ~clr_mask[`THP_ST_LOWSUP]) | low_ev;
      irq_n_q <= ~(txrdy_q | por_q | uo_q | wake_q | ext_q | low_q |
                   (~tx_reg_en & lvl_q));
    end
  end

  assign irq_request_out_n = irq_n_q;

  assign status_word = {tx_reg_en ? txrdy_q : lvl_q, por_q, uo_q, wake_q, ext_q, low_q,
                        (fcnt_q == 5'h00), 9'h000};
  assign tx_underrun_rx_overflow_flag = uo_q;

endmodule // thp_core

// ---- rtl/thp_regs.vh ----
`ifndef THP_REGS_VH
`define THP_REGS_VH

// Status word bit positions
`define THP_ST_TXRDY_FIFO 15
`define THP_ST_POR        14
`define THP_ST_UNDOVF     13
`define THP_ST_WAKE       12
`define THP_ST_EXTINT     11
`define THP_ST_LOWSUP     10
`define THP_ST_FIFOEMPTY  9
`define THP_ST_RESET      16'h0000

// Command decode
`define THP_CMD_TYPE_BIT  15
`define THP_OP_TXBYTE     8'hB8

// Transmit and receive data path
`define THP_TX_PRELOAD    16'hAAAA
`define THP_FIFO_DEPTH    16
`define THP_WORD_BITS     16

// Synchroniser reset levels: {low_supply, ext_int_n, fsel, sdi, cs_n, sck}
`define THP_PIN_RST       6'h1A

// Timing
`define THP_CLK_HZ        40000000
`define THP_MS_TIME_US    1000
`define THP_CAL_TIME_US   500
`define THP_CAL_PERIOD_S  30
`define THP_MS_CYCLES     ((`THP_CLK_HZ / 1000000) * `THP_MS_TIME_US)
`define THP_CAL_CYCLES    ((`THP_CLK_HZ / 1000000) * `THP_CAL_TIME_US)
`define THP_CAL_PERIOD_MS (`THP_CAL_PERIOD_S * 1000)

`endif

// ---- rtl/thp_sync.v ----
`timescale 1ns/10ps
module thp_sync #(
  parameter         W       = 6,
  parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
  // Clock and control
  input  wire         clk,
  input  wire         sys_rst,
  input  wire         ce,
  // Asynchronous inputs and their synchronised copies
  input  wire [W-1:0] d,
  output wire [W-1:0] q
);

  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      reg meta_q;
      reg sync_q;
      always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
          meta_q <= RST_VAL[i];
          sync_q <= RST_VAL[i];
        end else if (ce) begin
          meta_q <= d[i];
          sync_q <= meta_q;
        end
      end
      assign q[i] = sync_q;
    end
  endgenerate

endmodule // thp_sync

// ---- rtl/thp_wut.v ----
`timescale 1ns/10ps
`include "thp_regs.vh"
module thp_wut #(
  parameter [31:0] MS_CYCLES     = `THP_MS_CYCLES,
  parameter [31:0] CAL_CYCLES    = `THP_CAL_CYCLES,
  parameter [31:0] CAL_PERIOD_MS = `THP_CAL_PERIOD_MS
) (
  // Clock and control
  input  wire       clk,
  input  wire       sys_rst,
  input  wire       ce,
  // Configuration
  input  wire       wut_en,
  input  wire       osc_on,
  input  wire [7:0] wut_mant,
  input  wire [4:0] wut_exp,
  // Status
  output reg        ms_tick,
  output reg        wut_expire,
  output reg        cal_busy,
  output wire       osc_req
);

  reg  [31:0] ms_div_q;
  reg  [39:0] per_cnt_q;
  reg  [31:0] cal_wait_q;
  reg  [31:0] cal_cnt_q;
  wire [39:0] target;

  // Period is mantissa times 2^exp milliseconds, up to 255 * 2^31 ms (over 17 years)
  assign target  = {32'h00000000, wut_mant} << wut_exp;
  // Oscillator is forced on only for the calibration window
  assign osc_req = cal_busy;

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ms_div_q   <= 32'h00000000;
      per_cnt_q  <= 40'h0000000000;
      cal_wait_q <= 32'h00000000;
      cal_cnt_q  <= 32'h00000000;
      ms_tick    <= 1'b0;
      wut_expire <= 1'b0;
      cal_busy   <= 1'b1;
    end else if (ce) begin
      ms_tick    <= 1'b0;
      wut_expire <= 1'b0;
      if (ms_div_q == MS_CYCLES - 32'h00000001) begin
        ms_div_q <= 32'h00000000;
        ms_tick  <= 1'b1;
      end else begin
        ms_div_q <= ms_div_q + 32'h00000001;
      end
      if (!wut_en || target == 40'h0000000000) begin
        per_cnt_q <= 40'h0000000000;
      end else if (ms_tick) begin
        if (per_cnt_q + 40'h0000000001 >= target) begin
          per_cnt_q  <= 40'h0000000000;
          wut_expire <= 1'b1;
        end else begin
          per_cnt_q <= per_cnt_q + 40'h0000000001;
        end
      end
      // Calibration at start-up, then periodically, also in sleep
      if (cal_busy) begin
        if (osc_on) begin
          if (cal_cnt_q == CAL_CYCLES - 32'h00000001) begin
            cal_busy  <= 1'b0;
            cal_cnt_q <= 32'h00000000;
          end else begin
            cal_cnt_q <= cal_cnt_q + 32'h00000001;
          end
        end
      end else if (ms_tick) begin
        if (cal_wait_q == CAL_PERIOD_MS - 32'h00000001) begin
          cal_wait_q <= 32'h00000000;
          cal_busy   <= 1'b1;
        end else begin
          cal_wait_q <= cal_wait_q + 32'h00000001;
        end
      end
    end
  end

endmodule // thp_wut

// ---- verification/tb_thp_core.sv ----
`timescale 1ns/10ps
module tb_thp_core;
  logic        clk = 1'b0, sys_rst = 1'b1;
  logic        spi_sck, spi_cs_n, spi_sdi, spi_sdo;
  logic        txdata_fifo_select_pin = 1'b1, ext_int_n = 1'b1, low_supply_det = 1'b0;
  logic        tx_reg_en = 1'b0, tx_active = 1'b0, fifo_en = 1'b0, rx_active = 1'b0;
  logic [4:0]  fifo_level = 5'h04, sync_len = 5'h08;
  logic [15:0] sync_pattern_setting = 16'h002D;
  logic        wut_en = 1'b0, osc_on = 1'b1, tx_bit_stb = 1'b0, rx_bit_stb = 1'b0, rx_bit = 1'b0;
  logic        ce = 1'b1, duty_cycle_en = 1'b0, rx_enable, osc_req, cal_busy;
  logic        irq_request_out_n, fifo_full_pin, tx_mod_out;
  logic        tx_underrun_rx_overflow_flag, fifo_level_flag;
  logic [15:0] status_word, r;
  logic [7:0]  v;
  logic [11:0] pat = {8'h2D, 4'hB};
  logic [2:0]  ev [0:2] = '{3'h1, 3'h2, 3'h4};
  int          bp [0:2] = '{11, 10, 12};
  int          errors = 0, checks = 0, i;

  always #12.5 clk = ~clk;

  thp_core #(.MS_CYCLES(32'd10), .CAL_CYCLES(32'd5), .CAL_PERIOD_MS(32'd4)) DUT (
    .clk, .sys_rst, .ce, .spi_sck, .spi_cs_n, .spi_sdi, .spi_sdo,
    .txdata_fifo_select_pin, .ext_int_n, .low_supply_det, .irq_request_out_n,
    .fifo_full_pin, .tx_mod_out, .tx_reg_en, .tx_active, .fifo_en, .rx_active,
    .fifo_level, .sync_len, .sync_pattern_setting, .duty_cycle_en,
    .duty_cycle_setting(7'h00), .wut_en, .wut_mant(8'h01), .wut_exp(5'h00), .osc_on,
    .tx_bit_stb, .rx_bit_stb, .rx_bit, .status_word, .tx_underrun_rx_overflow_flag,
    .fifo_level_flag, .rx_enable, .osc_req, .cal_busy);
  thp_host_model host (.clk, .spi_sck, .spi_cs_n, .spi_sdi, .spi_sdo);

  task chk(input logic [15:0] got, input logic [15:0] exp);
    begin
      checks++;
      if (got !== exp) begin
        errors++;
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask

  task strobes(input int n);
    int k;
    begin
      // Start clear of any edge already due in this time step
      @(negedge clk);
      for (k = 0; k < n; k++) begin
        tx_bit_stb = 1'b1;
        @(negedge clk);
        tx_bit_stb = 1'b0;
        @(negedge clk);
        v = {v[6:0], tx_mod_out};
      end
    end
  endtask

  task complete_run;
    begin
      $display("checks=%0d errors=%0d", checks, errors);
      if (errors == 0 && checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
    end
  endtask

  initial begin
    #500000;
    errors++;
    complete_run;
  end

  initial begin
    repeat (6) @(negedge clk);
    chk(irq_request_out_n, 1'b0);
    chk(osc_req, 1'b1);
    sys_rst = 1'b0;
    repeat (3) @(negedge clk);
    chk(status_word, 16'h4200);
    chk(spi_sdo, 1'b0);
    chk(cal_busy, 1'b1);
    repeat (4) @(negedge clk);
    chk(cal_busy, 1'b0);
    chk(osc_req, 1'b0);
    host.xfer(16'h0000, r);
    chk(r, 16'h4200);
    repeat (6) @(negedge clk);
    chk(irq_request_out_n, 1'b1);
    $display("test reset done");
    // Event rows: external pulse, low supply, wake timeout
    txdata_fifo_select_pin = 1'b0;
    for (i = 0; i < 3; i++) begin
      ext_int_n = ~ev[i][0];
      low_supply_det = ev[i][1];
      wut_en = ev[i][2];
      repeat (40) @(negedge clk);
      ext_int_n = 1'b1;
      wut_en = 1'b0;
      chk(status_word[bp[i]], 1'b1);
      chk(irq_request_out_n, 1'b0);
      host.xfer(16'h0000, r);
      chk(r[bp[i]], 1'b1);
      repeat (6) @(negedge clk);
      chk(status_word[bp[i]], 1'b0);
      chk(irq_request_out_n, 1'b1);
      low_supply_det = 1'b0;
      $display("test event row %0d done", i);
    end
    // Transmit: preamble, byte hand-off, then underrun
    txdata_fifo_select_pin = 1'b1;
    tx_reg_en = 1'b1;
    tx_active = 1'b1;
    host.xfer(16'hB8DD, r);
    strobes(8);
    chk(v, 8'h55);
    chk(status_word[15], 1'b1);
    chk(tx_underrun_rx_overflow_flag, 1'b0);
    strobes(8);
    chk(tx_underrun_rx_overflow_flag, 1'b1);
    tx_reg_en = 1'b0;
    tx_active = 1'b0;
    $display("test transmit done");
    txdata_fifo_select_pin = 1'b0;
    repeat (6) @(negedge clk);
    chk(tx_mod_out, 1'b0);
    txdata_fifo_select_pin = 1'b1;
    repeat (6) @(negedge clk);
    chk(tx_mod_out, 1'b1);
    // Clock enable low must freeze the pin path
    ce = 1'b0;
    txdata_fifo_select_pin = 1'b0;
    repeat (6) @(negedge clk);
    chk(tx_mod_out, 1'b1);
    ce = 1'b1;
    repeat (6) @(negedge clk);
    chk(tx_mod_out, 1'b0);
    $display("test direct modulation done");
    // Duty cycle: receiver opens only after a timer expiry
    txdata_fifo_select_pin = 1'b1;
    duty_cycle_en = 1'b1;
    repeat (4) @(negedge clk);
    chk(rx_enable, 1'b0);
    wut_en = 1'b1;
    for (i = 0; i < 30 && rx_enable !== 1'b1; i++) @(negedge clk);
    chk(rx_enable, 1'b1);
    duty_cycle_en = 1'b0;
    wut_en = 1'b0;
    repeat (4) @(negedge clk);
    chk(rx_enable, 1'b0);
    $display("test duty cycle done");
    // Receive: sync word then four data bits at level four
    fifo_en = 1'b1;
    rx_active = 1'b1;
    repeat (4) @(negedge clk);
    for (i = 11; i >= 0; i--) begin
      rx_bit = pat[i];
      rx_bit_stb = 1'b1;
      @(negedge clk);
      rx_bit_stb = 1'b0;
      @(negedge clk);
      if (i == 1) chk(fifo_level_flag, 1'b0);
    end
    repeat (2) @(negedge clk);
    chk(fifo_level_flag, 1'b1);
    chk(fifo_full_pin, 1'b1);
    host.xfer(16'h0000, r);
    chk(r[14:11], 4'hB);
    $display("test receive done");
    complete_run;
  end
endmodule // tb_thp_core

// ---- verification/thp_core_checker.sv ----
`timescale 1ns/10ps
module thp_core_checker (
  // Clock and reset
  input wire        clk,
  input wire        sys_rst,
  input wire        ce,
  // Pins
  input wire        spi_sck,
  input wire        spi_cs_n,
  input wire        spi_sdo,
  input wire        txdata_fifo_select_pin,
  input wire        ext_int_n,
  input wire        low_supply_det,
  input wire        irq_request_out_n,
  input wire        fifo_full_pin,
  input wire        tx_mod_out,
  // Configuration and status
  input wire        tx_reg_en,
  input wire        fifo_en,
  input wire        rx_active,
  input wire [15:0] status_word,
  input wire        tx_underrun_rx_overflow_flag,
  input wire        fifo_level_flag
);
  default clocking cb @(posedge clk); endclocking
  // Frozen cycles are not judged: the pin path holds by design then
  default disable iff (sys_rst || !ce);
  a_sdo_idle_low: assert property (spi_cs_n [*4] |-> !spi_sdo)
    else $error("sdo not low while deselected");
  a_irq_ext_pulse: assert property ($fell(ext_int_n) |-> ##[1:8] !irq_request_out_n)
    else $error("no request after external pulse");
  a_irq_low_supply: assert property ($rose(low_supply_det) |-> ##[1:8] !irq_request_out_n)
    else $error("no request after low supply");
  a_irq_sticky_hold: assert property (|status_word[14:10] |-> ##1 !irq_request_out_n)
    else $error("request released with a pending source");
  a_irq_level: assert property (fifo_level_flag && rx_active && !tx_reg_en
                                |-> ##1 !irq_request_out_n)
    else $error("no request on fifo level");
  a_fifo_pin_level: assert property (fifo_en && fifo_level_flag |-> ##[0:2] fifo_full_pin)
    else $error("fifo pin missing level");
  a_direct_mod: assert property ((!tx_reg_en && $stable(txdata_fifo_select_pin)) [*6]
                                 |-> tx_mod_out == txdata_fifo_select_pin)
    else $error("modulation does not follow pin");
  a_sdo_on_fall: assert property ($changed(spi_sdo) && !txdata_fifo_select_pin
                                  |-> !$past(spi_sck) && !$past(spi_sck, 2))
    else $error("sdo changed near rising sck");
  c_ext: cover property ($fell(ext_int_n));
  c_level: cover property ($rose(fifo_level_flag));
  c_underrun: cover property ($rose(tx_underrun_rx_overflow_flag));
endmodule // thp_core_checker

bind thp_core thp_core_checker u_chk (.clk, .sys_rst, .ce, .spi_sck, .spi_cs_n, .spi_sdo,
  .txdata_fifo_select_pin, .ext_int_n, .low_supply_det, .irq_request_out_n, .fifo_full_pin,
  .tx_mod_out, .tx_reg_en, .fifo_en, .rx_active, .status_word, .tx_underrun_rx_overflow_flag,
  .fifo_level_flag);

// ---- verification/thp_host_model.sv ----
`timescale 1ns/10ps
module thp_host_model (
  // Clock reference
  input  wire clk,
  // Serial link
  output reg  spi_sck,
  output reg  spi_cs_n,
  output reg  spi_sdi,
  input  wire spi_sdo
);
  initial begin
    spi_sck = 1'b0;
    spi_cs_n = 1'b1;
    spi_sdi = 1'b0;
  end
  // 200 ns period keeps fifo reads under the quarter-crystal limit
  task xfer(input logic [15:0] w, output logic [15:0] r);
    integer i;
    begin
      @(negedge clk);
      spi_cs_n = 1'b0;
      for (i = 15; i >= 0; i--) begin
        spi_sdi = w[i];
        #100 spi_sck = 1'b1;
        r[i] = spi_sdo;
        #100 spi_sck = 1'b0;
      end
      #100 spi_cs_n = 1'b1;
      // Released line must not keep the last bit
      spi_sdi = ~spi_sdi;
      #100;
    end
  endtask
endmodule // thp_host_model
